// ### hw/dsp_seq_pkg.sv
package dsp_seq_pkg;
  // register offsets: 16-bit word addresses on the control port
  localparam logic [15:0] ADDR_CHECK_HIGH = 16'he200;
  localparam logic [15:0] ADDR_CHECK_LOW = 16'he201;
  localparam logic [15:0] ADDR_CHECK_ENABLE = 16'he202;
  localparam logic [15:0] ADDR_PIN_CONTROL = 16'he204;
  localparam logic [15:0] ADDR_RATE_SELECT = 16'he220;
  localparam logic [15:0] ADDR_CHECK_ERROR = 16'he225;
  localparam logic [15:0] ADDR_ERROR_MUTE = 16'he227;
  localparam logic [15:0] ADDR_CORE_RUN = 16'he228;
  localparam logic [15:0] ADDR_PEAK_COUNT = 16'he229;
  localparam logic [15:0] ADDR_FRAME_FAULT = 16'he22a;
  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_CHECK_MUTE = 1;
  localparam int PIN_SEL_W = 4;
  localparam logic [3:0] PIN_SEL_CHECK_ERROR = 4'h1;
  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // numeric formats
  localparam int CORE_W = 28;
  localparam int SAMPLE_W = 24;
  localparam int PROG_W = 43;
  // sequencing counts
  localparam logic [15:0] PC_START = 16'h2010;
  localparam logic [12:0] LIMIT_NORMAL = 13'h0e00;
  localparam logic [12:0] LIMIT_DOUBLE = 13'h0700;
  localparam logic [12:0] LIMIT_QUAD = 13'h0380;
  localparam logic [12:0] CHECK_FRAMES = 13'h1000;
  localparam int RAMP_SHIFT = 4;
  // program check code
  localparam logic [31:0] CHECK_POLY = 32'h04c11db7;
  localparam logic [31:0] CHECK_INIT = 32'hffffffff;

  typedef enum logic [1:0] {
    RATE_NORMAL = 2'b00,
    RATE_DOUBLE = 2'b01,
    RATE_QUAD = 2'b10
  } rate_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : dsp_seq_pkg

// ### hw/sample_format.sv
`timescale 1ns/1ps
module sample_format
  import dsp_seq_pkg::*;
(
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic [CORE_W-1:0] word_o,
  input wire logic [CORE_W-1:0] acc_i,
  output logic [SAMPLE_W-1:0] clip_o
);
  localparam int HEAD = CORE_W - SAMPLE_W;
  logic top_same;

  // headroom bits copy the sign so gains up to 24 dB do not clip
  assign word_o = {{HEAD{sample_i[SAMPLE_W-1]}}, sample_i}; // RULE2 RULE1
  // value fits in 24 bits only if the top five bits agree
  assign top_same = (acc_i[CORE_W-1:SAMPLE_W-1] == '0) ||
                    (acc_i[CORE_W-1:SAMPLE_W-1] == '1);

  always_comb begin
    if (top_same) begin
      clip_o = acc_i[SAMPLE_W-1:0];
    end else if (acc_i[CORE_W-1]) begin
      clip_o = {1'b1, {(SAMPLE_W-1){1'b0}}}; // RULE3
    end else begin
      clip_o = {1'b0, {(SAMPLE_W-1){1'b1}}}; // RULE3
    end
  end
endmodule : sample_format

// ### hw/program_check.sv
`timescale 1ns/1ps
module program_check
  import dsp_seq_pkg::*;
#(
  parameter int DEPTH = 4096,
  parameter int ADDR_W = 12,
  parameter logic [31:0] POLY = CHECK_POLY,
  parameter logic [31:0] INIT = CHECK_INIT
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic [ADDR_W-1:0] ram_addr_o,
  output logic ram_rd_o,
  input wire logic [PROG_W-1:0] ram_data_i,
  output logic done_o,
  output logic [31:0] code_o
);
  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_SCAN = 2'b01,
    CHK_FLUSH = 2'b10
  } chk_state_t;

  chk_state_t state;
  logic data_valid;
  logic [31:0] code;

  function automatic logic [31:0] crc_word(input logic [31:0] crc,
                                           input logic [PROG_W-1:0] w);
    logic [31:0] c;
    logic fb;
    c = crc;
    for (int i = PROG_W - 1; i >= 0; i--) begin
      fb = c[31] ^ w[i];
      c = {c[30:0], 1'b0} ^ (fb ? POLY : 32'h00000000); // RULE23
    end
    return c;
  endfunction : crc_word

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= CHK_IDLE;
      ram_addr_o <= '0;
      ram_rd_o <= 1'b0;
    end else if (abort_i) begin
      state <= CHK_IDLE;
      ram_rd_o <= 1'b0;
    end else begin
      case (state)
        CHK_IDLE: begin
          if (start_i) begin
            state <= CHK_SCAN;
            ram_addr_o <= '0;
            ram_rd_o <= 1'b1;
          end
        end
        CHK_SCAN: begin
          if (ram_addr_o == ADDR_W'(DEPTH - 1)) begin
            state <= CHK_FLUSH;
            ram_rd_o <= 1'b0;
          end else begin
            ram_addr_o <= ram_addr_o + ADDR_W'(1);
          end
        end
        CHK_FLUSH: begin
          if (!data_valid) begin
            state <= CHK_IDLE;
          end
        end
        default: state <= CHK_IDLE;
      endcase
    end
  end

  // ram answers one cycle after the read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_valid <= 1'b0;
      code <= INIT;
      done_o <= 1'b0;
      code_o <= '0;
    end else begin
      data_valid <= ram_rd_o && !abort_i;
      done_o <= 1'b0;
      if (state == CHK_IDLE && start_i) begin
        code <= INIT;
      end else if (data_valid) begin
        code <= crc_word(code, ram_data_i); // RULE23
      end
      if (state == CHK_FLUSH && data_valid && !abort_i) begin
        done_o <= 1'b1;
        code_o <= crc_word(code, ram_data_i);
      end
    end
  end
endmodule : program_check

// ### hw/dsp_core_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: data and parameters are signed 5.23 fixed point, 28 bits.
// RULE2: 24-bit serial input samples are sign-extended to 28 bits.
// RULE3: outputs are clipped to 24 bits, range -1.0 to 1.0 minus 1 LSB.
// RULE4: normal rate allows 3584 instruction cycles per sample period.
// RULE5: double and quad speed cut the per-sample budget, set by register.
// RULE6: budget is 1792 at double rate, 896 at quad rate.
// RULE7: no program after power-up; host loads program memory first.
// RULE8: program counter starts stepping on each new audio frame.
// RULE9: jump-to-start returns counter to 0x2010, then waits for a frame.
// RULE10: a frame arriving before return corrupts output until reset.
// RULE11: run register bit 0, reset 0, starts or halts the core.
// RULE12: host sets the run bit last during initialisation.
// RULE13: halting the core ramps serial outputs down to zero.
// RULE14: expected code in two 16-bit registers, high then low, reset 0.
// RULE15: host writes both code halves before enabling the check.
// RULE16: enable bit at E202, active high, default off.
// RULE17: while enabled, recompute and compare code every 4096 frames.
// RULE18: mismatch sets a read-only sticky error bit 0 of E225.
// RULE19: the sticky error clears whenever the enable bit is low.
// RULE20: host recovers by disabling, reloading program, re-enabling.
// RULE21: error reaches the multipurpose pin only when selected.
// RULE22: error mute register bit 1 lets a check error mute the core.
// RULE23: check code is a parameterised 32-bit cyclic code over all words.
module dsp_core_sequencer
  import dsp_seq_pkg::*;
#(
  parameter int PROG_DEPTH = 4096,
  parameter int PROG_AW = 12,
  parameter logic [31:0] POLY = CHECK_POLY
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire reg_req_t bus_req_i,
  output logic [15:0] rd_data_o,
  input wire logic frame_start_i,
  input wire logic jump_start_i,
  output logic [15:0] pc_o,
  output logic exec_o,
  output logic core_run_o,
  output logic core_mute_o,
  output logic frame_fault_o,
  input wire logic [SAMPLE_W-1:0] sample_in_i,
  output logic [CORE_W-1:0] core_word_o,
  input wire logic [CORE_W-1:0] acc_word_i,
  input wire logic acc_valid_i,
  output logic [SAMPLE_W-1:0] sample_out_o,
  output logic [PROG_AW-1:0] check_addr_o,
  output logic check_rd_o,
  input wire logic [PROG_W-1:0] check_data_i,
  output logic multipurpose_pin_o
);
  typedef enum logic [1:0] {
    SEQ_WAIT = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_FAULT = 2'b10
  } seq_state_t;

  seq_state_t state;
  logic [15:0] check_expected_high;
  logic [15:0] check_expected_low;
  logic check_enable;
  logic check_error_sticky;
  logic [PIN_SEL_W-1:0] pin_select;
  rate_t rate;
  logic check_mute;
  logic [12:0] instr_count;
  logic [15:0] peak_count;
  logic [12:0] frame_count;
  logic check_start;
  logic check_done;
  logic [31:0] check_code;
  logic [CORE_W-1:0] ext_word;
  logic [SAMPLE_W-1:0] clip_word;
  logic ramp_down;
  logic signed [SAMPLE_W-1:0] ramp_step;
  logic [15:0] next_rd_data;

  function automatic logic [12:0] rate_limit(input rate_t r);
    case (r)
      RATE_DOUBLE: rate_limit = LIMIT_DOUBLE; // RULE6
      RATE_QUAD: rate_limit = LIMIT_QUAD; // RULE6
      default: rate_limit = LIMIT_NORMAL; // RULE4
    endcase
  endfunction : rate_limit

  function automatic logic hit(input reg_req_t q, input logic [15:0] a);
    hit = q.wr && (q.addr == a);
  endfunction : hit

  sample_format u_format (
    .sample_i(sample_in_i),
    .word_o(ext_word),
    .acc_i(acc_word_i),
    .clip_o(clip_word)
  );

  program_check #(
    .DEPTH(PROG_DEPTH),
    .ADDR_W(PROG_AW),
    .POLY(POLY),
    .INIT(CHECK_INIT)
  ) u_check (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(check_start),
    .abort_i(!check_enable),
    .ram_addr_o(check_addr_o),
    .ram_rd_o(check_rd_o),
    .ram_data_i(check_data_i),
    .done_o(check_done),
    .code_o(check_code)
  );

  // control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      check_expected_high <= RESET_WORD; // RULE14
      check_expected_low <= RESET_WORD; // RULE14
      check_enable <= 1'b0; // RULE16
      core_run_o <= 1'b0; // RULE11 RULE7
      pin_select <= '0;
      rate <= RATE_NORMAL;
      check_mute <= 1'b0; // RULE22
    end else begin
      if (hit(bus_req_i, ADDR_CHECK_HIGH)) begin
        check_expected_high <= bus_req_i.wdata; // RULE14
      end
      if (hit(bus_req_i, ADDR_CHECK_LOW)) begin
        check_expected_low <= bus_req_i.wdata; // RULE14
      end
      if (hit(bus_req_i, ADDR_CHECK_ENABLE)) begin
        check_enable <= bus_req_i.wdata[BIT_ENABLE]; // RULE16
      end
      if (hit(bus_req_i, ADDR_CORE_RUN)) begin
        core_run_o <= bus_req_i.wdata[BIT_RUN]; // RULE11
      end
      if (hit(bus_req_i, ADDR_PIN_CONTROL)) begin
        pin_select <= bus_req_i.wdata[PIN_SEL_W-1:0];
      end
      if (hit(bus_req_i, ADDR_RATE_SELECT)) begin
        rate <= rate_t'(bus_req_i.wdata[1:0]); // RULE5
      end
      if (hit(bus_req_i, ADDR_ERROR_MUTE)) begin
        check_mute <= bus_req_i.wdata[BIT_CHECK_MUTE]; // RULE22
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_comb begin
    next_rd_data = 16'h0000;
    case (bus_req_i.addr)
      ADDR_CHECK_HIGH: next_rd_data = check_expected_high;
      ADDR_CHECK_LOW: next_rd_data = check_expected_low;
      ADDR_CHECK_ENABLE: next_rd_data = {15'h0000, check_enable};
      ADDR_PIN_CONTROL: next_rd_data = {12'h000, pin_select};
      ADDR_RATE_SELECT: next_rd_data = {14'h0000, rate};
      ADDR_CHECK_ERROR: next_rd_data = {15'h0000, check_error_sticky};
      ADDR_ERROR_MUTE: next_rd_data = {14'h0000, check_mute, 1'b0};
      ADDR_CORE_RUN: next_rd_data = {15'h0000, core_run_o};
      ADDR_PEAK_COUNT: next_rd_data = peak_count;
      ADDR_FRAME_FAULT: next_rd_data = {15'h0000, frame_fault_o};
      default: next_rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= bus_req_i.rd ? next_rd_data : 16'h0000;
    end
  end

  // program counter sequencing
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SEQ_WAIT;
      pc_o <= PC_START;
      exec_o <= 1'b0;
      instr_count <= '0;
      peak_count <= 16'h0000;
      frame_fault_o <= 1'b0;
    end else begin
      case (state)
        SEQ_WAIT: begin
          if (frame_start_i && core_run_o) begin
            state <= SEQ_RUN; // RULE8
            pc_o <= PC_START;
            exec_o <= 1'b1;
            instr_count <= '0;
          end
        end
        SEQ_RUN: begin
          if (frame_start_i) begin
            // unrecoverable by design: only reset leaves this state
            state <= SEQ_FAULT; // RULE10
            frame_fault_o <= 1'b1; // RULE10
            exec_o <= 1'b0;
          end else if (jump_start_i) begin
            state <= SEQ_WAIT; // RULE9
            pc_o <= PC_START; // RULE9
            exec_o <= 1'b0;
            peak_count <= {3'b000, instr_count};
          end else if (!core_run_o) begin
            state <= SEQ_WAIT; // RULE11
            pc_o <= PC_START;
            exec_o <= 1'b0;
          end else if (instr_count == rate_limit(rate) - 13'h0001) begin
            // budget spent: stop fetching, next frame reports a fault
            exec_o <= 1'b0; // RULE4 RULE6
          end else if (exec_o) begin
            pc_o <= pc_o + 16'h0001; // RULE8
            instr_count <= instr_count + 13'h0001;
          end
        end
        SEQ_FAULT: begin
          exec_o <= 1'b0;
        end
        default: state <= SEQ_WAIT;
      endcase
    end
  end

  // periodic program memory check
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_count <= '0;
      check_start <= 1'b0;
    end else begin
      check_start <= 1'b0;
      if (!check_enable) begin
        frame_count <= '0;
      end else if (frame_start_i) begin
        if (frame_count == CHECK_FRAMES - 13'h0001) begin
          frame_count <= '0;
          check_start <= 1'b1; // RULE17
        end else begin
          frame_count <= frame_count + 13'h0001;
        end
      end
    end
  end

  // clear by enable low wins: the check is aborted in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      check_error_sticky <= 1'b0;
    end else if (!check_enable) begin
      check_error_sticky <= 1'b0; // RULE19
    end else if (check_done &&
                 check_code != {check_expected_high, check_expected_low}) begin
      check_error_sticky <= 1'b1; // RULE17 RULE18
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      multipurpose_pin_o <= 1'b0;
      core_mute_o <= 1'b0;
    end else begin
      multipurpose_pin_o <= check_error_sticky &&
                            (pin_select == PIN_SEL_CHECK_ERROR); // RULE21
      core_mute_o <= check_error_sticky && check_mute; // RULE22
    end
  end

  // sample path
  assign ramp_down = !core_run_o || core_mute_o;
  always_comb begin
    ramp_step = $signed(sample_out_o) >>> RAMP_SHIFT;
    // small positive values would never reach zero by shifting alone
    if (ramp_step == '0 && sample_out_o != '0) begin
      ramp_step = SAMPLE_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_word_o <= '0;
      sample_out_o <= '0;
    end else begin
      core_word_o <= ext_word; // RULE1 RULE2
      if (ramp_down) begin
        if (frame_start_i) begin
          sample_out_o <= sample_out_o - ramp_step; // RULE13
        end
      end else if (acc_valid_i) begin
        sample_out_o <= clip_word; // RULE3
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence new_frame_s;
    frame_start_i && state == SEQ_WAIT && core_run_o;
  endsequence
  sequence returned_s;
    state == SEQ_WAIT && pc_o == PC_START && !exec_o;
  endsequence

  sign_extend_a: assert property ( // RULE2
    $past(reset_n_i) |->
    core_word_o == {{4{$past(sample_in_i[23])}}, $past(sample_in_i)})
    else $error("sign extension wrong");
  clip_range_a: assert property ( // RULE3
    acc_valid_i && !ramp_down && !acc_word_i[CORE_W-1] &&
    acc_word_i[CORE_W-2:SAMPLE_W-1] != '0 |=>
    sample_out_o == 24'h7fffff)
    else $error("positive clip wrong");
  frame_start_a: assert property ( // RULE8
    new_frame_s |=> state == SEQ_RUN && pc_o == PC_START && exec_o)
    else $error("frame did not start counter");
  jump_return_a: assert property ( // RULE9
    state == SEQ_RUN && !frame_start_i && jump_start_i |=> returned_s)
    else $error("jump did not return to start");
  frame_overrun_a: assert property ( // RULE10
    state == SEQ_RUN && frame_start_i |=> frame_fault_o [*2])
    else $error("overrun not flagged");
  budget_cap_a: assert property ( // RULE6
    state == SEQ_RUN |-> instr_count < rate_limit(rate))
    else $error("instruction budget exceeded");
  run_write_a: assert property ( // RULE11
    hit(bus_req_i, ADDR_CORE_RUN) |=>
    core_run_o == $past(bus_req_i.wdata[0]))
    else $error("run bit not stored");
  error_set_a: assert property ( // RULE18
    check_enable && check_done &&
    check_code != {check_expected_high, check_expected_low} |=>
    check_error_sticky)
    else $error("mismatch not flagged");
  error_clear_a: assert property ( // RULE19
    !check_enable |=> !check_error_sticky)
    else $error("error not cleared");
  pin_route_a: assert property ( // RULE21
    ##1 multipurpose_pin_o == ($past(check_error_sticky) &&
    $past(pin_select) == PIN_SEL_CHECK_ERROR))
    else $error("pin routing wrong");
  check_period_a: assert property ( // RULE17
    check_start |-> $past(check_enable) && $past(frame_start_i))
    else $error("check started off period");
endmodule : dsp_core_sequencer

// ### verification/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model
  import dsp_seq_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 12
) (
  input wire logic clk_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic rd_i,
  output logic [PROG_W-1:0] data_o
);
  // contents stay unknown until the host loads them
  logic [PROG_W-1:0] mem [DEPTH];
  always @(posedge clk_i) begin
    // idle cycles show the inverse so a stale word never passes as fresh
    if (rd_i) begin
      data_o <= mem[addr_i];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : prog_mem_model

// ### verification/dsp_core_sequencer_tb.sv
`timescale 1ns/1ps
module dsp_core_sequencer_tb;
  import dsp_seq_pkg::*;
  localparam int DEPTH = 16;
  localparam logic [15:0] ADDRS [6] = '{ADDR_CHECK_HIGH, ADDR_CHECK_LOW,
    ADDR_CHECK_ENABLE, ADDR_CHECK_ERROR, ADDR_CORE_RUN, 16'he2ff};
  localparam rate_t RATES [3] = '{RATE_NORMAL, RATE_DOUBLE, RATE_QUAD};
  localparam logic [12:0] LIMITS [3] = '{LIMIT_NORMAL, LIMIT_DOUBLE,
    LIMIT_QUAD};
  localparam logic [27:0] ACC [4] = '{28'h8000000, 28'h0123456,
    28'hff00000, 28'h7ffffff};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  reg_req_t req = '0;
  logic frame_i = 1'b0;
  logic jump_i = 1'b0;
  logic acc_valid = 1'b0;
  logic [SAMPLE_W-1:0] sample_in = '0;
  logic [CORE_W-1:0] acc_word = '0;
  logic [15:0] rd_data, pc;
  logic exec, run, mute, fault, chk_rd, pin;
  logic [CORE_W-1:0] core_word;
  logic [SAMPLE_W-1:0] sample_out;
  logic [11:0] chk_addr;
  logic [PROG_W-1:0] chk_data;
  logic [31:0] seed = 32'h17069ffc;
  logic [31:0] exp_q [$];
  logic rd_seen = 1'b0;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int scan_count = 0;

  always #4 clk_i = ~clk_i;

  dsp_core_sequencer #(.PROG_DEPTH(DEPTH)) i_dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .bus_req_i(req), .rd_data_o(rd_data),
    .frame_start_i(frame_i), .jump_start_i(jump_i), .pc_o(pc),
    .exec_o(exec), .core_run_o(run), .core_mute_o(mute),
    .frame_fault_o(fault), .sample_in_i(sample_in),
    .core_word_o(core_word), .acc_word_i(acc_word),
    .acc_valid_i(acc_valid), .sample_out_o(sample_out),
    .check_addr_o(chk_addr), .check_rd_o(chk_rd),
    .check_data_i(chk_data), .multipurpose_pin_o(pin));

  prog_mem_model #(.DEPTH(DEPTH), .AW(12)) i_mem (.clk_i(clk_i),
    .addr_i(chk_addr), .rd_i(chk_rd), .data_o(chk_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [23:0] clip(input logic signed [27:0] v);
    if (v > 28'sh07fffff) return 24'h7fffff;
    if (v < -28'sh0800000) return 24'h800000;
    return v[23:0];
  endfunction : clip

  // msb-first shift, no reflection, no final inversion
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    logic fb;
    c = CHECK_INIT;
    for (int i = 0; i < n; i++) begin
      for (int b = PROG_W - 1; b >= 0; b--) begin
        fb = c[31] ^ i_mem.mem[i][b];
        c = {c[30:0], 1'b0} ^ (fb ? CHECK_POLY : 32'h0);
      end
    end
    return c;
  endfunction : crc_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    @(posedge clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
  endtask : rd

  task automatic frame();
    @(posedge clk_i);
    frame_i <= 1'b1;
    @(posedge clk_i);
    frame_i <= 1'b0;
  endtask : frame

  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    cycles++;
    if (rd_seen) begin
      check(rd_data, exp_q.pop_front());
    end
    rd_seen <= req.rd;
    if (chk_rd === 1'b1) begin
      check(chk_addr, scan_count % DEPTH);
      scan_count++;
    end
    if (cycles == 60000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] code;
    logic [63:0] w;
    logic [23:0] o;
    int n;
    int s0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1 check(pc, PC_START);
    check(run, 1'b0);
    foreach (ADDRS[i]) rd(ADDRS[i], 16'h0);
    r = rnd();
    wr(ADDR_CHECK_HIGH, r[31:16]);
    wr(ADDR_CHECK_LOW, r[15:0]);
    wr(ADDR_CHECK_ERROR, 16'h0001);
    rd(ADDR_CHECK_HIGH, r[31:16]);
    rd(ADDR_CHECK_LOW, r[15:0]);
    rd(ADDR_CHECK_ERROR, 16'h0);
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 32'h800000 : (i == 1) ? 32'h7fffff : rnd();
      @(posedge clk_i);
      sample_in <= r[23:0];
      @(posedge clk_i);
      #1 check(core_word, {{4{r[23]}}, r[23:0]});
    end
    wr(ADDR_CORE_RUN, 16'h1);
    #1 check(run, 1'b1);
    frame();
    for (int i = 0; i < 10; i++) begin
      #1 check(exec, 1'b1);
      check(pc, PC_START + i);
      @(posedge clk_i);
    end
    jump_i <= 1'b1;
    @(posedge clk_i);
    jump_i <= 1'b0;
    #1 check(exec, 1'b0);
    check(pc, PC_START);
    rd(ADDR_PEAK_COUNT, 16'h000a);
    foreach (RATES[k]) begin
      wr(ADDR_RATE_SELECT, {14'h0, RATES[k]});
      frame();
      n = 0;
      #1;
      while (exec === 1'b1 && n < 5000) begin
        n++;
        @(posedge clk_i);
        #1;
      end
      check(n, LIMITS[k]);
      wr(ADDR_CORE_RUN, 16'h0);
      wr(ADDR_CORE_RUN, 16'h1);
    end
    foreach (ACC[k]) begin
      @(posedge clk_i);
      acc_word <= ACC[k];
      acc_valid <= 1'b1;
      @(posedge clk_i);
      acc_valid <= 1'b0;
      #1 check(sample_out, clip(ACC[k]));
    end
    o = 24'h7fffff;
    wr(ADDR_CORE_RUN, 16'h0);
    for (int i = 0; i < 24; i++) begin
      frame();
      if (o != 24'h0) o = o - (((o >> 4) != 0) ? (o >> 4) : 24'h1);
      #1 check(sample_out, o);
    end
    wr(ADDR_CORE_RUN, 16'h1);
    frame();
    frame();
    #1 check(fault, 1'b1);
    check(exec, 1'b0);
    rd(ADDR_FRAME_FAULT, 16'h0001);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1 check(fault, 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      w = {rnd(), rnd()};
      i_mem.mem[i] = w[PROG_W-1:0];
    end
    code = crc_of(DEPTH);
    // second pass carries a wrong low half, then the host clears the error by disabling the check
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CHECK_ENABLE, 16'h0);
      wr(ADDR_CHECK_HIGH, code[31:16]);
      wr(ADDR_CHECK_LOW, code[15:0] ^ p[15:0]);
      wr(ADDR_CHECK_ENABLE, 16'h1);
      s0 = scan_count;
      repeat (4095) frame();
      repeat (DEPTH + 40) @(posedge clk_i);
      check(scan_count - s0, 0);
      rd(ADDR_CHECK_ERROR, 16'h0);
      frame();
      repeat (DEPTH + 40) @(posedge clk_i);
      check(scan_count - s0, DEPTH);
      rd(ADDR_CHECK_ERROR, {15'h0, p[0]});
    end
    wr(ADDR_PIN_CONTROL, 16'h0);
    repeat (2) @(posedge clk_i);
    #1 check(pin, 1'b0);
    check(mute, 1'b0);
    wr(ADDR_PIN_CONTROL, {12'h0, PIN_SEL_CHECK_ERROR});
    wr(ADDR_ERROR_MUTE, 16'h2);
    repeat (2) @(posedge clk_i);
    #1 check(pin, 1'b1);
    check(mute, 1'b1);
    rd(ADDR_CHECK_ERROR, 16'h1);
    wr(ADDR_CHECK_ENABLE, 16'h0);
    repeat (2) @(posedge clk_i);
    #1 check(mute, 1'b0);
    check(pin, 1'b0);
    rd(ADDR_CHECK_ERROR, 16'h0);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule : dsp_core_sequencer_tb
